/* File: common/spdc_map.vh */
// Constants for the serial potentiometer command unit
`ifndef SPDC_MAP_VH
`define SPDC_MAP_VH
`define SPDC_DTYPE_MSB     7
`define SPDC_DTYPE_LSB     4
`define SPDC_SEL_BIT       1
`define SPDC_DIR_BIT       0
`define SPDC_OP_MSB        7
`define SPDC_OP_LSB        5
`define SPDC_RB_BIT        3
`define SPDC_RA_BIT        2
`define SPDC_OP_RD_WIPER   3'h4
`define SPDC_OP_WR_WIPER   3'h5
`define SPDC_OP_RD_SET     3'h5
`define SPDC_OP_WR_SET     3'h6
`define SPDC_OP_XFR_TO_WPR 3'h6
`define SPDC_OP_XFR_TO_SET 3'h7
`define SPDC_OP_STATUS     3'h2
`define SPDC_REG_W         10
`define SPDC_CLK_HZ        10000000
`define SPDC_NV_WRITE_MS   10
`define SPDC_NV_WRITE_CYC  ((`SPDC_CLK_HZ / 1000) * `SPDC_NV_WRITE_MS)
`define SPDC_WPR_DELAY_US  10
`define SPDC_WPR_DELAY_CYC ((`SPDC_CLK_HZ / 1000000) * `SPDC_WPR_DELAY_US)
`define SPDC_SET_RESET     10'h200
`endif

/* File: rtl/spdc_command_unit.v */
// Serial command decoder and register store of a digital potentiometer
// Function
// R01 - Four ten-bit nonvolatile setting registers, readable and writable serially.
// R02 - Copy between any setting register and wiper position, either direction.
// R03 - Any setting register change is a nonvolatile write, done within 10 ms.
// R04 - Setting register holds ten-bit tap code, bit 9 most significant.
// R05 - Status flag reads 1 during a nonvolatile write, else 0.
// R06 - Wiper position register is ten-bit volatile, selects the wiper tap.
// R07 - First byte after select falls is identification with device-type code.
// R08 - Execute only when slave select bit equals address pin level.
// R09 - Direction bit in identification byte selects read or write.
// R10 - Second byte holds three-bit opcode and two register select bits.
// R11 - Read wiper: dir 1 op 100; write wiper: dir 0 op 101.
// R12 - Read setting: dir 1 op 101; write setting: dir 0 op 110.
// R13 - Dir 1 op 110 copies selected setting into wiper position.
// R14 - Dir 0 op 111 copies wiper position into selected setting, nonvolatile.
// R15 - Dir 1 op 010, select 00, low bit 1 returns status.
// R16 - Register and status accesses are four-byte transactions.
// R17 - Copy commands are identification plus instruction bytes only.
// R18 - Wiper output follows a copy only after wiper response delay.
// R19 - Copy into setting register takes the nonvolatile write cycle time.
// R20 - Save starts on chip select rise after a complete write command.
// R21 - Host polls write-in-progress status to learn write completion.
// R22 - Read bits are driven on the serial clock falling edge.
// R23 - Input bits are sampled on the serial clock rising edge.
// R24 - Write-lock low blocks every nonvolatile setting write.
// R25 - At power-up wiper position loads from setting slot zero.
// R26 - Data travels MSB first: six spare bits, bits 9-8, then 7-0.
// R27 - Serial output is high impedance except during matched read shifting.
`include "spdc_map.vh"
`default_nettype none
module spdc_command_unit #(
  parameter integer      NV_WRITE_CYC  = `SPDC_NV_WRITE_CYC,
  parameter integer      WPR_DELAY_CYC = `SPDC_WPR_DELAY_CYC,
  parameter [3:0]        DEVICE_TYPE   = 4'hA,
  parameter [`SPDC_REG_W-1:0] SET_RESET = `SPDC_SET_RESET
) (
  input  wire                    clk,
  input  wire                    reset_n,
  input  wire                    sck,
  input  wire                    cs_n,
  input  wire                    si,
  input  wire                    slave_select_bit,
  input  wire                    write_lock_n,
  output reg                     so_ff,
  output reg                     so_oe_ff,
  output reg  [`SPDC_REG_W-1:0]  wiper_tap_ff,
  output reg                     write_progress_ff
);
  // DEVICE_TYPE default is arbitrary
  localparam ST_IDLE = 3'h0;
  localparam ST_ID   = 3'h1;
  localparam ST_INS  = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_DONE = 3'h4;
  localparam ST_SKIP = 3'h5;

  reg  [2:0] sck_s_ff, cs_s_ff, si_s_ff, a_s_ff, wl_s_ff;
  reg  [2:0] state_ff;
  reg  [3:0] bit_cnt_ff;
  reg  [7:0] shift_ff;
  reg        dir_ff;
  reg  [2:0] op_ff;
  reg  [1:0] sel_ff;
  reg        ins_low_ff;
  reg  [`SPDC_REG_W-1:0] wiper_position_register_ff;
  reg  [`SPDC_REG_W-1:0] stored_setting_register_ff [0:3];
  reg  [15:0] out_ff;
  reg         rd_act_ff;
  reg         pend_save_ff;
  reg  [1:0]  pend_sel_ff;
  reg  [`SPDC_REG_W-1:0] pend_val_ff;
  reg         boot_ff;
  reg         wpr_start_ff;
  reg         nv_start_ff;
  reg  [1:0]  nv_sel_ff;
  reg  [`SPDC_REG_W-1:0] nv_val_ff;
  reg  [7:0]  data_hi_ff;

  wire sck_r   = sck_s_ff[1] & ~sck_s_ff[2];
  wire sck_f   = ~sck_s_ff[1] & sck_s_ff[2];
  wire cs_fall = ~cs_s_ff[1] & cs_s_ff[2];
  wire cs_rise = cs_s_ff[1] & ~cs_s_ff[2];
  wire si_s    = si_s_ff[1];
  wire [7:0] byte_in = {shift_ff[6:0], si_s};
  wire       byte_end = sck_r & (bit_cnt_ff == 4'h7);
  wire nv_busy;
  wire nv_done;
  wire wpr_busy;
  wire wpr_done;

  wire is_rd_wpr = dir_ff & (op_ff == `SPDC_OP_RD_WIPER) & (sel_ff == 2'b00);  // [R11]
  wire is_wr_wpr = ~dir_ff & (op_ff == `SPDC_OP_WR_WIPER);                       // [R11]
  wire is_rd_set = dir_ff & (op_ff == `SPDC_OP_RD_SET);                          // [R12]
  wire is_wr_set = ~dir_ff & (op_ff == `SPDC_OP_WR_SET);                         // [R12]
  wire is_x_wpr  = dir_ff & (op_ff == `SPDC_OP_XFR_TO_WPR);                      // [R13]
  wire is_x_set  = ~dir_ff & (op_ff == `SPDC_OP_XFR_TO_SET);                     // [R14]
  wire is_status = dir_ff & (op_ff == `SPDC_OP_STATUS) & (sel_ff == 2'b00)
                   & ins_low_ff;                                                 // [R15]
  wire is_read   = is_rd_wpr | is_rd_set | is_status;

  // Pins cross two flops before any use; third stage gives edges
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_s_ff <= 3'h0;
      cs_s_ff  <= 3'h7;
      si_s_ff  <= 3'h0;
      a_s_ff   <= 3'h0;
      wl_s_ff  <= 3'h0;
    end else begin
      sck_s_ff <= {sck_s_ff[1:0], sck};
      cs_s_ff  <= {cs_s_ff[1:0], cs_n};
      si_s_ff  <= {si_s_ff[1:0], si};
      a_s_ff   <= {a_s_ff[1:0], slave_select_bit};
      wl_s_ff  <= {wl_s_ff[1:0], write_lock_n};
    end
  end

  spdc_wait_timer #(.COUNT(NV_WRITE_CYC), .W(24)) u_nv_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (nv_start_ff),
    .busy_ff (nv_busy),
    .done_ff (nv_done)
  );

  spdc_wait_timer #(.COUNT(WPR_DELAY_CYC), .W(24)) u_wpr_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (wpr_start_ff),
    .busy_ff (wpr_busy),
    .done_ff (wpr_done)
  );

  // Serial frame decoder
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff     <= ST_IDLE;
      bit_cnt_ff   <= 4'h0;
      shift_ff     <= 8'h00;
      dir_ff       <= 1'b0;
      op_ff        <= 3'h0;
      sel_ff       <= 2'b00;
      ins_low_ff   <= 1'b0;
      data_hi_ff   <= 8'h00;
      out_ff       <= 16'h0000;
      rd_act_ff    <= 1'b0;
      so_ff        <= 1'b0;
      so_oe_ff     <= 1'b0;
      pend_save_ff <= 1'b0;
      pend_sel_ff  <= 2'b00;
      pend_val_ff  <= {`SPDC_REG_W{1'b0}};
      boot_ff      <= 1'b1;
      wpr_start_ff <= 1'b0;
      nv_start_ff  <= 1'b0;
      nv_sel_ff    <= 2'b00;
      nv_val_ff    <= {`SPDC_REG_W{1'b0}};
      wiper_position_register_ff <= {`SPDC_REG_W{1'b0}};
    end else begin
      wpr_start_ff <= 1'b0;
      nv_start_ff  <= 1'b0;
      if (boot_ff) begin
        boot_ff <= 1'b0;
        wiper_position_register_ff <= stored_setting_register_ff[0];  // [R25]
        wpr_start_ff <= 1'b1;
      end
      if (sck_r) begin
        shift_ff   <= byte_in;                                          // [R23]
        bit_cnt_ff <= (bit_cnt_ff == 4'h7) ? 4'h0 : bit_cnt_ff + 4'h1;
      end
      if (cs_s_ff[1]) begin
        state_ff  <= ST_IDLE;
        rd_act_ff <= 1'b0;
        so_oe_ff  <= 1'b0;                                              // [R27]
        if (cs_rise && pend_save_ff) begin
          pend_save_ff <= 1'b0;
          if (wl_s_ff[1] && !nv_busy) begin                             // [R24]
            nv_start_ff <= 1'b1;                                        // [R20]
            nv_sel_ff   <= pend_sel_ff;
            nv_val_ff   <= pend_val_ff;
          end
        end
      end else begin
        if (cs_fall) begin
          state_ff     <= ST_ID;                                        // [R07]
          bit_cnt_ff   <= 4'h0;
          pend_save_ff <= 1'b0;
        end
        case (state_ff)
          ST_IDLE: begin
            // Held here until the select edge moves the frame on
          end
          ST_ID: begin
            if (byte_end) begin
              if (byte_in[`SPDC_DTYPE_MSB:`SPDC_DTYPE_LSB] == DEVICE_TYPE
                  && byte_in[`SPDC_SEL_BIT] == a_s_ff[1]) begin         // [R07] [R08]
                dir_ff   <= byte_in[`SPDC_DIR_BIT];                     // [R09]
                state_ff <= ST_INS;
              end else begin
                state_ff <= ST_SKIP;                                    // [R08]
              end
            end
          end
          ST_INS: begin
            if (byte_end) begin
              op_ff      <= byte_in[`SPDC_OP_MSB:`SPDC_OP_LSB];         // [R10]
              sel_ff     <= {byte_in[`SPDC_RB_BIT], byte_in[`SPDC_RA_BIT]};
              ins_low_ff <= byte_in[0];
              state_ff   <= ST_DATA;
            end
          end
          ST_DATA: begin
            // Instruction just latched; decide copy or data phase
            if (is_x_wpr || is_x_set) begin                             // [R17]
              if (is_x_wpr) begin
                wiper_position_register_ff <= stored_setting_register_ff[sel_ff];  // [R13]
                wpr_start_ff <= 1'b1;                                   // [R18]
              end else begin
                pend_save_ff <= 1'b1;                                   // [R14] [R19]
                pend_sel_ff  <= sel_ff;
                pend_val_ff  <= wiper_position_register_ff;
              end
              state_ff <= ST_SKIP;
            end else if (is_read) begin
              out_ff <= is_status ? {15'h0000, write_progress_ff}
                      : is_rd_wpr ? {6'h00, wiper_position_register_ff}
                      : {6'h00, stored_setting_register_ff[sel_ff]};    // [R26]
              rd_act_ff <= 1'b1;
              state_ff  <= ST_DONE;
            end else if (is_wr_wpr || is_wr_set) begin
              state_ff <= ST_DONE;
            end else begin
              state_ff <= ST_SKIP;
            end
          end
          ST_DONE: begin
            // Two data bytes, MSB first
            if (sck_f && rd_act_ff) begin
              so_ff    <= out_ff[15];                                   // [R22]
              so_oe_ff <= 1'b1;                                         // [R27]
              out_ff   <= {out_ff[14:0], 1'b0};
            end
            if (byte_end && !rd_act_ff) begin
              if (data_hi_ff[7] == 1'b0) begin
                data_hi_ff <= {1'b1, byte_in[6:0]};
                pend_val_ff[9:8] <= byte_in[1:0];                       // [R26]
              end else begin
                data_hi_ff <= 8'h00;
                state_ff   <= ST_SKIP;                                  // [R16]
                if (is_wr_wpr) begin
                  wiper_position_register_ff <= {pend_val_ff[9:8], byte_in};  // [R11]
                  wpr_start_ff <= 1'b1;
                end else begin
                  pend_save_ff <= 1'b1;                                 // [R12] [R20]
                  pend_sel_ff  <= sel_ff;
                  pend_val_ff  <= {pend_val_ff[9:8], byte_in};
                end
              end
            end
          end
          ST_SKIP: begin
            // Reads keep shifting until chip select rises
            if (sck_f && rd_act_ff) begin
              so_ff  <= out_ff[15];
              out_ff <= {out_ff[14:0], 1'b0};
            end
          end
          default: state_ff <= ST_IDLE;
        endcase
        if (rd_act_ff && state_ff == ST_DONE && byte_end && out_ff == 16'h0000
            && bit_cnt_ff == 4'h7) begin
          state_ff <= ST_DONE;
        end
      end
      if (cs_s_ff[1]) begin
        data_hi_ff <= 8'h00;
      end
    end
  end

  // Nonvolatile setting store with reset-time contents
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_set
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          stored_setting_register_ff[gi] <= SET_RESET;                  // [R01] [R04]
        end else if (nv_done && {30'h0, nv_sel_ff} == gi) begin
          stored_setting_register_ff[gi] <= nv_val_ff;                  // [R03] [R02]
        end
      end
    end
  endgenerate

  // Wiper tap output and busy flag
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wiper_tap_ff      <= {`SPDC_REG_W{1'b0}};
      write_progress_ff <= 1'b0;
    end else begin
      write_progress_ff <= nv_start_ff | (nv_busy & ~nv_done);          // [R05]
      if (wpr_done) begin
        wiper_tap_ff <= wiper_position_register_ff;                      // [R06] [R18]
      end
    end
  end
endmodule // spdc_command_unit
`default_nettype wire

/* File: rtl/spdc_wait_timer.v */
// Down counter that times one fixed wait after a start pulse
`default_nettype none
module spdc_wait_timer #(
  parameter integer COUNT = 16,
  parameter integer W     = 24
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire         start,
  output reg          busy_ff,
  output reg          done_ff
);
  reg  [W-1:0] cnt_ff;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff  <= {W{1'b0}};
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start) begin
        cnt_ff  <= COUNT[W-1:0] - {{(W-1){1'b0}}, 1'b1};
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        if (cnt_ff == {W{1'b0}}) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // spdc_wait_timer
`default_nettype wire

/* File: tb/spdc_command_unit_chk.sv */
// Port checker for the potentiometer command unit, bound to its top module
`default_nettype none
module spdc_unit_chk #(
  parameter int NV_WRITE_CYC = 50
) (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       sck,
  input wire logic       cs_n,
  input wire logic       si,
  input wire logic       slave_select_bit,
  input wire logic       write_lock_n,
  input wire logic       so_ff,
  input wire logic       so_oe_ff,
  input wire logic [9:0] wiper_tap_ff,
  input wire logic       write_progress_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  int wip_cnt_ff;
  // Length of the current busy period
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) wip_cnt_ff <= 0;
    else wip_cnt_ff <= write_progress_ff ? wip_cnt_ff + 1 : 0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence save_start;
    $rose(write_progress_ff);
  endsequence
  sequence lock_held;
    !write_lock_n [*8];
  endsequence
  chk_save_on_deselect: assert property (save_start |-> cs_n)
    else $error("save started while selected");
  chk_save_hold: assert property (save_start |-> write_progress_ff [*8])
    else $error("busy flag dropped early");
  chk_save_min_len: assert property ($fell(write_progress_ff) |-> wip_cnt_ff >= NV_WRITE_CYC)
    else $error("save shorter than write cycle");
  chk_save_max_len: assert property (wip_cnt_ff <= NV_WRITE_CYC + 8)
    else $error("save longer than write cycle");
  chk_lock_blocks: assert property (lock_held |-> not save_start)
    else $error("save started while locked");
  chk_out_idle: assert property (cs_n [*4] |-> !so_oe_ff)
    else $error("output driven while deselected");
  chk_out_selected: assert property ($rose(so_oe_ff) |-> !cs_n)
    else $error("output enabled without select");
  chk_out_fall_edge: assert property (so_oe_ff && $changed(so_ff) |-> !$past(sck))
    else $error("output changed in high phase");
endmodule // spdc_unit_chk
bind spdc_command_unit spdc_unit_chk #(.NV_WRITE_CYC(NV_WRITE_CYC)) spdc_unit_chk_i (
  .clk(clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .si(si),
  .slave_select_bit(slave_select_bit), .write_lock_n(write_lock_n), .so_ff(so_ff),
  .so_oe_ff(so_oe_ff), .wiper_tap_ff(wiper_tap_ff), .write_progress_ff(write_progress_ff));
`default_nettype wire

/* File: tb/spdc_command_unit_tb.sv */
// Self-checking bench for the potentiometer command unit
`default_nettype none
`define CK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module spdc_command_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NV = 400;
  logic        clk = 1'b0, reset_n = 1'b0, ssb = 1'b0, wl_n = 1'b1, oe_seen = 1'b0;
  logic        oe_clr = 1'b0;
  wire         sck, cs_n, si, so_ff, so_oe_ff, wip;
  wire  [9:0]  tap;
  logic [7:0]  idm = 8'h00;
  logic [31:0] rx;
  int          failures = 0, checks = 0, seed = 32'hB014, v, m_wpr;
  int          m_set[4];
  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (so_oe_ff) oe_seen <= 1'b1;
    else if (oe_clr) oe_seen <= 1'b0;
  end
  spdc_host spdc_host_i (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .so(so_ff),
    .so_oe(so_oe_ff));
  spdc_command_unit #(.NV_WRITE_CYC(NV), .WPR_DELAY_CYC(5)) spdc_command_unit_i (
    .clk(clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .si(si),
    .slave_select_bit(ssb), .write_lock_n(wl_n), .so_ff(so_ff), .so_oe_ff(so_oe_ff),
    .wiper_tap_ff(tap), .write_progress_ff(wip));
  task automatic final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic frame(input logic d, input logic [2:0] op, input int r, input logic lo,
                       input int val, input int nb);
    spdc_host_i.xfer({{4'hA, 2'b00, ssb, d} ^ idm, op, 1'b0, r[1:0], 1'b0, lo, 6'h00,
                      val[9:0]}, nb, rx);
  endtask
  task automatic rd(input logic [2:0] op, input int r, input int e, input string n);
    frame(1'b1, op, r, 1'b0, 0, 32);
    `CK(n, e[9:0], rx[9:0])
  endtask
  task automatic st(input logic e);
    frame(1'b1, 3'h2, 0, 1'b1, 0, 32);
    `CK("status", e, rx[0])
  endtask
  task automatic nv(input logic [2:0] op, input int r, input int val, input int nb);
    int k;
    frame(1'b0, op, r, 1'b0, val, nb);
    `CK("wip", 1'b1, wip)
    st(1'b1);
    for (k = 0; k < 6; k++) begin
      frame(1'b1, 3'h2, 0, 1'b1, 0, 32);
      if (rx[0] === 1'b0) break;
    end
    `CK("poll", 1'b1, k < 6)
    `CK("wip", 1'b0, wip)
    if (k == 6) final_report;
  endtask
  task automatic tapw;
    int k;
    for (k = 0; k < 40 && tap !== m_wpr[9:0]; k++) @(posedge clk);
    `CK("tap", m_wpr[9:0], tap)
    if (k == 40) final_report;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    final_report;
  end
  initial begin
    for (int i = 0; i < 4; i++) m_set[i] = 10'h200;
    m_wpr = m_set[0];
    v = $random(seed);
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    ssb <= v[0];
    repeat (6) @(posedge clk);
    tapw;
    for (int i = 0; i < 4; i++) rd(3'h5, i, m_set[i], "set");
    rd(3'h4, 0, m_wpr, "wiper");
    `CK("oe", 1'b1, oe_seen)
    m_wpr = $random(seed) & 32'h3FF;
    frame(1'b0, 3'h5, 0, 1'b0, m_wpr, 32);
    tapw;
    rd(3'h4, 0, m_wpr, "wiper");
    for (int i = 0; i < 4; i++) begin
      m_set[i] = $random(seed) & 32'h3FF;
      nv(3'h6, i, m_set[i], 32);
    end
    for (int i = 0; i < 4; i++) rd(3'h5, i, m_set[i], "set");
    frame(1'b1, 3'h6, 2, 1'b0, 0, 16);
    m_wpr = m_set[2];
    tapw;
    rd(3'h4, 0, m_wpr, "wiper");
    m_wpr = $random(seed) & 32'h3FF;
    frame(1'b0, 3'h5, 0, 1'b0, m_wpr, 32);
    nv(3'h7, 1, 0, 16);
    m_set[1] = m_wpr;
    rd(3'h5, 1, m_set[1], "set");
    wl_n <= 1'b0;
    frame(1'b0, 3'h6, 3, 1'b0, m_set[3] ^ 1, 32);
    st(1'b0);
    frame(1'b0, 3'h7, 3, 1'b0, 0, 16);
    st(1'b0);
    wl_n <= 1'b1;
    rd(3'h5, 3, m_set[3], "set");
    frame(1'b0, 3'h6, 0, 1'b0, m_set[0] ^ 32'h3FF, 24);
    st(1'b0);
    rd(3'h5, 0, m_set[0], "set");
    idm = 8'h02;
    frame(1'b0, 3'h5, 0, 1'b0, m_wpr ^ 5, 32);
    oe_clr <= 1'b1;
    @(posedge clk) oe_clr <= 1'b0;
    frame(1'b1, 3'h4, 0, 1'b0, 0, 32);
    `CK("oe", 1'b0, oe_seen)
    idm = 8'h90;
    frame(1'b0, 3'h5, 0, 1'b0, m_wpr ^ 6, 32);
    idm = 8'h00;
    rd(3'h4, 0, m_wpr, "wiper");
    final_report;
  end
endmodule // spdc_command_unit_tb
`default_nettype wire

/* File: tb/spdc_host.sv */
// Serial bus master model for the potentiometer command unit
`default_nettype none
module spdc_host (
  input  wire logic clk,
  output var  logic sck,
  output var  logic cs_n,
  output var  logic si,
  input  wire logic so,
  input  wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic so_last;
  wire  sol = so_oe ? so : ~so_last;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    so_last = 1'b0;
  end
  // Released line must not show a stale bit
  always @(posedge clk) begin
    if (so_oe) so_last <= so;
  end
  // Frame of nb bits MSB first; sck idles low between frames
  task automatic xfer(input logic [31:0] tx, input int nb, output logic [31:0] rx);
    rx = '0;
    @(posedge clk) cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 31; i > 31 - nb; i--) begin
      @(posedge clk) begin
        sck <= 1'b0;
        si <= tx[i];
      end
      repeat (3) @(posedge clk);
      @(posedge clk) sck <= 1'b1;
      repeat (3) @(posedge clk);
      rx = {rx[30:0], sol};
    end
    @(posedge clk) sck <= 1'b0;
    repeat (3) @(posedge clk);
    @(posedge clk) cs_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule // spdc_host
`default_nettype wire
